// ---- include/tw8_pkg.sv ----
// Constants and carrier types of the 8-bit timer waveform generator
package tw8_pkg;

    // ======================================================================
    // Register map (byte addresses on the AXI4-Lite port)
    localparam int          ADDR_W      = 8;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_PRESC   = 8'h04;
    localparam logic [7:0]  OFS_FORCE   = 8'h08;
    localparam logic [7:0]  OFS_COUNT   = 8'h0C;
    localparam logic [7:0]  OFS_CMPA    = 8'h10;
    localparam logic [7:0]  OFS_CMPB    = 8'h14;
    localparam logic [7:0]  OFS_FLAGS   = 8'h18;
    localparam logic [7:0]  OFS_PORT    = 8'h1C;
    localparam logic [7:0]  OFS_STATUS  = 8'h20;

    // ======================================================================
    // Field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTB_LSB = 4;
    localparam int CTRL_ACTA_LSB = 6;
    localparam int CTRL_RUN_BIT  = 8;
    localparam int FORCE_A_BIT   = 0;
    localparam int FORCE_B_BIT   = 1;
    localparam int FLG_OVF_BIT   = 0;
    localparam int FLG_CMPA_BIT  = 1;
    localparam int FLG_CMPB_BIT  = 2;
    localparam int PORT_OUTA_BIT = 0;
    localparam int PORT_OUTB_BIT = 1;
    localparam int PORT_DIRA_BIT = 2;
    localparam int PORT_DIRB_BIT = 3;
    localparam int STAT_WAVA_BIT = 0;
    localparam int STAT_WAVB_BIT = 1;

    // ======================================================================
    // Codes and values
    localparam logic [2:0] MODE_NORMAL    = 3'h0;
    localparam logic [2:0] MODE_CTC       = 3'h2;
    localparam logic [2:0] MODE_FAST_MAX  = 3'h3;
    localparam logic [2:0] MODE_FAST_CMPA = 3'h7;
    localparam logic [1:0] ACT_NONE       = 2'h0;
    localparam logic [1:0] ACT_TOGGLE     = 2'h1;
    localparam logic [1:0] ACT_CLEAR      = 2'h2;
    localparam logic [1:0] ACT_SET        = 2'h3;
    localparam logic [7:0] CNT_MAX        = 8'hFF;
    localparam logic [7:0] CNT_BOTTOM     = 8'h00;
    localparam logic       WAVE_RST       = 1'b0;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ======================================================================
    // Carriers
    typedef struct packed {
        logic [7:0]  awaddr;
        logic        awvalid;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        wvalid;
        logic        bready;
        logic [7:0]  araddr;
        logic        arvalid;
        logic        rready;
    } tw8_axil_req_s;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } tw8_axil_rsp_s;

    typedef struct packed {
        logic wave_a_o;
        logic wave_a_oe;
        logic wave_b_o;
        logic wave_b_oe;
    } tw8_pin_s;

    typedef struct packed {
        logic overflow_flag;
        logic compare_a_flag;
        logic compare_b_flag;
    } tw8_flag_s;

endpackage

// ---- verilog/tw8_waveform_gen.sv ----
// 8-bit timer counting sequence and waveform outputs with AXI4-Lite access
`timescale 1ns/1ps

// Functional notes
// R01 - Reset clears both waveform output bits to zero.
// R02 - Nonzero action field puts waveform bit on pin; direction bit keeps enable.
// R03 - Software sets the direction bit before the waveform reaches the pin.
// R04 - Port override follows the action field, not the counting mode. The code also disconnects fast PWM action 1 (R20).
// R05 - Action zero leaves the waveform bit alone at a match.
// R06 - New action acts at next match; force strobe acts at once, non-PWM.
// R07 - Mode field sets counting; action field sets only output behaviour.
// R08 - Mode zero counts up, never clears, wraps 0xFF to 0x00.
// R09 - Normal mode sets overflow flag as counter becomes zero.
// R10 - Counter writes accepted any time in normal mode.
// R11 - Mode 2 clears counter on match with compare value A.
// R12 - Mode 2 compare A unbuffered; lower value makes counter wrap first.
// R13 - Mode 2 sets compare A flag when counter reaches top.
// R14 - Mode 2 action 1 toggles output A each match; A=0 toggles each tick.
// R15 - Mode 2 sets overflow flag on the move from max to 0x00.
// R16 - Modes 3 and 7 count bottom to top; top 0xFF or compare A.
// R17 - Fast PWM action 2 clears at match, sets at bottom; 3 opposite.
// R18 - Fast PWM counts up to top, clears on the following tick.
// R19 - Fast PWM sets overflow flag each time counter reaches top.
// R20 - Fast PWM action 1 toggles A only with mode msb; else disconnected.
// R21 - Fast PWM compare values double buffered, toggle mode included.
// R22 - Fast PWM A=0 gives one-tick spike; A=max gives constant level.
// R23 - Match sets compare flag on next tick; writing one clears it.
// R24 - Counter write blocks compare matches for the next tick.
// R25 - Counter write beats clear and count; stopped timer never ticks.
// R26 - Apart from register writes, counter, flags and outputs change only on timer tick cycles.
module tw8_waveform_gen
    import tw8_pkg::*;
#(
    parameter int PRESC_W = 8
) (
    input  wire logic          aclk,
    input  wire logic          aresetn,
    input  wire tw8_axil_req_s s_axil_req,
    output tw8_axil_rsp_s      s_axil_rsp,
    output tw8_pin_s           pin,
    output tw8_flag_s          flags
);

    // ======================================================================
    // State
    typedef struct packed {
        logic [7:0]         aw_addr;
        logic               aw_full;
        logic [31:0]        w_data;
        logic [3:0]         w_strb;
        logic               w_full;
        tw8_axil_rsp_s      rsp;
        logic [2:0]         mode;
        logic [1:0]         act_a;
        logic [1:0]         act_b;
        logic               run;
        logic [PRESC_W-1:0] presc_div;
        logic [PRESC_W-1:0] presc_cnt;
        logic [7:0]         count;
        logic [7:0]         cmpa_buf;
        logic [7:0]         cmpa_act;
        logic [7:0]         cmpb_buf;
        logic [7:0]         cmpb_act;
        logic               block;
        tw8_flag_s          flg;
        logic               wave_a;
        logic               wave_b;
        logic               port_a;
        logic               port_b;
        logic               dir_a;
        logic               dir_b;
        tw8_pin_s           pin;
    } tw8_state_s;

    tw8_state_s state_reg;
    tw8_state_s state_next;

    // ======================================================================
    // Helpers
    function automatic logic [31:0] merge_strb(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  strb
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic apply_act(
        input logic       cur,
        input logic [1:0] act
    );
        logic res;
        res = cur;
        unique case (act)
            ACT_NONE:   res = cur;                          // see R05
            ACT_TOGGLE: res = ~cur;
            ACT_CLEAR:  res = 1'b0;
            ACT_SET:    res = 1'b1;
        endcase
        return res;
    endfunction

    // ======================================================================
    // Next-state logic
    always_comb begin
        logic        wr_fire;
        logic [7:0]  wr_addr;
        logic [31:0] wr_data;
        logic        tick;
        logic        is_fast;
        logic        is_ctc;
        logic [7:0]  top;
        logic        at_top;
        logic        match_a;
        logic        match_b;
        logic        ctc_clear;
        logic        disc_a;
        logic        disc_b;
        logic [31:0] rd;

        state_next = state_reg;
        wr_fire    = 1'b0;
        wr_addr    = state_reg.aw_addr;
        wr_data    = 32'h0000_0000;
        rd         = 32'h0000_0000;

        // ------------------------------------------------ timer tick divider
        tick = 1'b0;
        if (!state_reg.run) begin
            state_next.presc_cnt = '0;                      // see R25
        end else if (state_reg.presc_cnt == state_reg.presc_div) begin
            tick                 = 1'b1;
            state_next.presc_cnt = '0;
        end else begin
            state_next.presc_cnt = state_reg.presc_cnt + 1'b1;
        end

        // ------------------------------------------------ counter unit
        is_fast = (state_reg.mode[1:0] == MODE_FAST_MAX[1:0]);
        is_ctc  = (state_reg.mode == MODE_CTC);
        top     = (state_reg.mode == MODE_FAST_CMPA) ? state_reg.cmpa_act
                                                     : CNT_MAX;  // see R16
        at_top  = (state_reg.count == top);
        // A counter write suppresses the comparator for one tick
        match_a = (state_reg.count == state_reg.cmpa_act)
                  && !state_reg.block;                      // see R24
        match_b = (state_reg.count == state_reg.cmpb_act)
                  && !state_reg.block;                      // see R24
        ctc_clear = is_ctc && match_a;                      // see R11

        if (tick) begin                                     // see R26
            state_next.block = 1'b0;
            if ((is_fast && at_top) || ctc_clear) begin
                state_next.count = CNT_BOTTOM;              // see R18
            end else begin
                // Plain 8-bit increment wraps 0xFF to 0x00
                state_next.count = state_reg.count + 8'h01; // see R08
            end

            if (is_fast) begin
                if (at_top) begin
                    state_next.flg.overflow_flag = 1'b1;    // see R19
                end
            end else if (state_reg.count == CNT_MAX && !ctc_clear) begin
                state_next.flg.overflow_flag = 1'b1;        // see R09 R15
            end else if (ctc_clear && state_reg.count == CNT_MAX) begin
                state_next.flg.overflow_flag = 1'b1;        // see R15
            end

            if (match_a) begin
                state_next.flg.compare_a_flag = 1'b1;       // see R13 R23
            end
            if (match_b) begin
                state_next.flg.compare_b_flag = 1'b1;       // see R23
            end

            // ---------------------------------------------- waveform logic
            if (is_fast) begin
                // Bottom action is applied after the match, so a compare
                // value equal to top yields a steady level
                if (state_reg.act_a[1]) begin
                    if (match_a) begin
                        state_next.wave_a =
                            (state_reg.act_a == ACT_SET);   // see R17
                    end
                    if (at_top) begin
                        state_next.wave_a =
                            (state_reg.act_a == ACT_CLEAR); // see R17 R22
                    end
                end else if (state_reg.act_a == ACT_TOGGLE
                             && state_reg.mode[2] && match_a) begin
                    state_next.wave_a = ~state_reg.wave_a;  // see R20
                end
                if (state_reg.act_b[1]) begin
                    if (match_b) begin
                        state_next.wave_b =
                            (state_reg.act_b == ACT_SET);   // see R17
                    end
                    if (at_top) begin
                        state_next.wave_b =
                            (state_reg.act_b == ACT_CLEAR); // see R17
                    end
                end
            end else begin
                if (match_a) begin
                    state_next.wave_a =
                        apply_act(state_reg.wave_a, state_reg.act_a); // see R14
                end
                if (match_b) begin
                    state_next.wave_b =
                        apply_act(state_reg.wave_b, state_reg.act_b);
                end
            end

            // Buffered compare values load as the counter leaves top
            if (is_fast && at_top) begin
                state_next.cmpa_act = state_reg.cmpa_buf;   // see R21
                state_next.cmpb_act = state_reg.cmpb_buf;   // see R21
            end
        end

        // ------------------------------------------------ AXI write path
        if (!state_reg.aw_full && s_axil_req.awvalid) begin
            state_next.aw_full = 1'b1;
            state_next.aw_addr = s_axil_req.awaddr;
        end
        if (!state_reg.w_full && s_axil_req.wvalid) begin
            state_next.w_full = 1'b1;
            state_next.w_data = s_axil_req.wdata;
            state_next.w_strb = s_axil_req.wstrb;
        end
        if (state_reg.rsp.bvalid && s_axil_req.bready) begin
            state_next.rsp.bvalid = 1'b0;
        end
        if (state_reg.aw_full && state_reg.w_full && !state_reg.rsp.bvalid)
        begin
            wr_fire               = 1'b1;
            state_next.aw_full    = 1'b0;
            state_next.w_full     = 1'b0;
            state_next.rsp.bvalid = 1'b1;
            state_next.rsp.bresp  = RESP_OKAY;
        end

        if (wr_fire) begin
            unique case (wr_addr)
                OFS_CTRL: begin
                    wr_data = merge_strb({23'h0, state_reg.run,
                        state_reg.act_a, state_reg.act_b, 1'b0,
                        state_reg.mode}, state_reg.w_data,
                        state_reg.w_strb);
                    state_next.mode  = wr_data[CTRL_MODE_LSB +: 3]; // see R07
                    state_next.act_a = wr_data[CTRL_ACTA_LSB +: 2]; // see R06
                    state_next.act_b = wr_data[CTRL_ACTB_LSB +: 2];
                    state_next.run   = wr_data[CTRL_RUN_BIT];
                end
                OFS_PRESC: begin
                    wr_data = merge_strb(32'(state_reg.presc_div),
                        state_reg.w_data, state_reg.w_strb);
                    state_next.presc_div = wr_data[PRESC_W-1:0];
                end
                OFS_FORCE: begin
                    // Force only moves the outputs: no flag, no counter
                    if (!is_fast && state_reg.w_strb[0]) begin
                        if (state_reg.w_data[FORCE_A_BIT]) begin
                            state_next.wave_a = apply_act(
                                state_next.wave_a, state_reg.act_a); // see R06
                        end
                        if (state_reg.w_data[FORCE_B_BIT]) begin
                            state_next.wave_b = apply_act(
                                state_next.wave_b, state_reg.act_b); // see R06
                        end
                    end
                end
                OFS_COUNT: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.count = state_reg.w_data[7:0]; // see R10 R25
                        state_next.block = 1'b1;                // see R24
                    end
                end
                OFS_CMPA: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.cmpa_buf = state_reg.w_data[7:0];
                    end
                end
                OFS_CMPB: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.cmpb_buf = state_reg.w_data[7:0];
                    end
                end
                OFS_FLAGS: begin
                    // Set wins: a flag set by the tick above in the same cycle is not cleared
                    if (state_reg.w_strb[0]) begin
                        if (state_reg.w_data[FLG_OVF_BIT]
                            && !(tick && (is_fast ? at_top
                                 : state_reg.count == CNT_MAX))) begin
                            state_next.flg.overflow_flag = 1'b0;
                        end
                        if (state_reg.w_data[FLG_CMPA_BIT]
                            && !(tick && match_a)) begin
                            state_next.flg.compare_a_flag = 1'b0; // see R23
                        end
                        if (state_reg.w_data[FLG_CMPB_BIT]
                            && !(tick && match_b)) begin
                            state_next.flg.compare_b_flag = 1'b0; // see R23
                        end
                    end
                end
                OFS_PORT: begin
                    if (state_reg.w_strb[0]) begin
                        state_next.port_a = state_reg.w_data[PORT_OUTA_BIT];
                        state_next.port_b = state_reg.w_data[PORT_OUTB_BIT];
                        state_next.dir_a  = state_reg.w_data[PORT_DIRA_BIT];
                        state_next.dir_b  = state_reg.w_data[PORT_DIRB_BIT];
                    end
                end
                OFS_STATUS: begin
                end
                default: begin
                    state_next.rsp.bresp = RESP_SLVERR;
                end
            endcase
        end

        // Unbuffered modes use the written compare value directly
        if (!is_fast) begin
            state_next.cmpa_act = state_next.cmpa_buf;      // see R12
            state_next.cmpb_act = state_next.cmpb_buf;
        end

        state_next.rsp.awready = !state_next.aw_full;
        state_next.rsp.wready  = !state_next.w_full;

        // ------------------------------------------------ AXI read path
        if (state_reg.rsp.rvalid && s_axil_req.rready) begin
            state_next.rsp.rvalid = 1'b0;
        end
        if (state_reg.rsp.arready && s_axil_req.arvalid) begin
            state_next.rsp.rvalid = 1'b1;
            state_next.rsp.rresp  = RESP_OKAY;
            unique case (s_axil_req.araddr)
                OFS_CTRL:   rd = {23'h0, state_reg.run, state_reg.act_a,
                                  state_reg.act_b, 1'b0, state_reg.mode};
                OFS_PRESC:  rd = 32'(state_reg.presc_div);
                OFS_FORCE:  rd = 32'h0000_0000;
                OFS_COUNT:  rd = {24'h0, state_reg.count};
                OFS_CMPA:   rd = {24'h0, state_reg.cmpa_buf};
                OFS_CMPB:   rd = {24'h0, state_reg.cmpb_buf};
                OFS_FLAGS:  rd = {29'h0, state_reg.flg.compare_b_flag,
                                  state_reg.flg.compare_a_flag,
                                  state_reg.flg.overflow_flag};
                OFS_PORT:   rd = {28'h0, state_reg.dir_b, state_reg.dir_a,
                                  state_reg.port_b, state_reg.port_a};
                OFS_STATUS: rd = {30'h0, state_reg.wave_b,
                                  state_reg.wave_a};
                default: begin
                    rd                   = 32'h0000_0000;
                    state_next.rsp.rresp = RESP_SLVERR;
                end
            endcase
            state_next.rsp.rdata = rd;
        end
        state_next.rsp.arready = !state_next.rsp.rvalid;

        // ------------------------------------------------ pin override
        // Toggle code 1 in fast PWM without the mode msb, and always for
        // output B, leaves the pin to the port
        disc_a = (state_next.mode[1:0] == MODE_FAST_MAX[1:0])
                 && (state_next.act_a == ACT_TOGGLE)
                 && !state_next.mode[2];                    // see R20
        disc_b = (state_next.mode[1:0] == MODE_FAST_MAX[1:0])
                 && (state_next.act_b == ACT_TOGGLE);       // see R20
        state_next.pin.wave_a_o =
            ((state_next.act_a != ACT_NONE) && !disc_a)
            ? state_next.wave_a : state_next.port_a;        // see R02 R04
        state_next.pin.wave_b_o =
            ((state_next.act_b != ACT_NONE) && !disc_b)
            ? state_next.wave_b : state_next.port_b;        // see R02 R04
        // Driver enable stays with the direction bit alone
        state_next.pin.wave_a_oe = state_next.dir_a;        // see R03
        state_next.pin.wave_b_oe = state_next.dir_b;        // see R03
    end

    // ======================================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg        <= '0;
            state_reg.wave_a <= WAVE_RST;                   // see R01
            state_reg.wave_b <= WAVE_RST;                   // see R01
        end else begin
            state_reg <= state_next;
        end
    end

    // ======================================================================
    // Outputs
    assign s_axil_rsp = state_reg.rsp;
    assign pin        = state_reg.pin;
    assign flags      = state_reg.flg;

endmodule

// ---- dv/tw8_load.sv ----
// Pin load model with pull-ups on both waveform pins
`timescale 1ns/1ps
module tw8_load
    import tw8_pkg::*;
(
    input  wire tw8_pin_s pin,
    output logic          lvl_a,
    output logic          lvl_b
);
    // ==========
    // Undriven pins float high, so a lost enable shows up as a one
    assign lvl_a = pin.wave_a_oe ? pin.wave_a_o : 1'b1;
    assign lvl_b = pin.wave_b_oe ? pin.wave_b_o : 1'b1;
endmodule

// ---- dv/tw8_chk_sva.sv ----
// Port assertions for the timer waveform generator
`timescale 1ns/1ps
module tw8_chk
    import tw8_pkg::*;
(
    input wire logic          aclk,
    input wire logic          aresetn,
    input wire tw8_axil_req_s s_axil_req,
    input wire tw8_axil_rsp_s s_axil_rsp,
    input wire tw8_pin_s      pin,
    input wire tw8_flag_s     flags
);
    // ==========
    // Handshake steps
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_wt;
        s_axil_req.awvalid && s_axil_rsp.awready
            && s_axil_req.wvalid && s_axil_rsp.wready;
    endsequence
    sequence s_rt;
        s_axil_req.arvalid && s_axil_rsp.arready;
    endsequence
    a_reset_clear: assert property (
        $rose(aresetn) |-> pin == '0 && flags == '0)
        else $error("outputs left set by reset");
    a_ovf_w1c: assert property (
        $fell(flags.overflow_flag) |-> $rose(s_axil_rsp.bvalid))
        else $error("overflow flag fell without a write");
    a_cmpa_w1c: assert property (
        $fell(flags.compare_a_flag) |-> $rose(s_axil_rsp.bvalid))
        else $error("compare flag fell without a write");
    a_rd_answer: assert property (s_rt |=> s_axil_rsp.rvalid)
        else $error("read answer late");
    a_wr_answer: assert property (s_wt |-> ##2 s_axil_rsp.bvalid)
        else $error("write answer late");
    a_b_hold: assert property (
        s_axil_rsp.bvalid && !s_axil_req.bready
            |=> s_axil_rsp.bvalid && $stable(s_axil_rsp.bresp))
        else $error("write answer dropped");
    a_r_hold: assert property (
        s_axil_rsp.rvalid && !s_axil_req.rready
            |=> s_axil_rsp.rvalid && $stable(s_axil_rsp.rdata))
        else $error("read answer dropped");
    a_aw_drop: assert property (
        s_axil_req.awvalid && s_axil_rsp.awready
            |=> !s_axil_rsp.awready)
        else $error("address ready stayed high");
endmodule

// ---- dv/tb.sv ----
// Self-checking bench for the timer waveform generator
`timescale 1ns/1ps
module tb;
    import tw8_pkg::*;
    // ==========
    // Design, load and checks
    logic          aclk = 1'b0;
    logic          aresetn = 1'b0;
    tw8_axil_req_s req = '0;
    tw8_axil_rsp_s rsp;
    tw8_pin_s      pin;
    tw8_flag_s     flags;
    logic          lvl_a;
    logic          lvl_b;
    logic [7:0]    c;
    int            hi;
    int            mismatches = 0;
    int            n_compared = 0;
    always #5 aclk = ~aclk;
    tw8_waveform_gen uut (.aclk(aclk), .aresetn(aresetn), .s_axil_req(req),
        .s_axil_rsp(rsp), .pin(pin), .flags(flags));
    tw8_load load (.pin(pin), .lvl_a(lvl_a), .lvl_b(lvl_b));
    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic expire();
        mismatches++;
        $display("[ERR] %0t wait ran out", $time);
        tally_and_finish();
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    function automatic int exp_hi(input logic [7:0] cv, input bit inv);
        int h;
        h = (cv == 8'hFF) ? 256 : int'(cv) + 1;
        return inv ? 256 - h : h;
    endfunction
    // Ready is raised late on purpose so the hold checks get exercised
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) req.bready <= 1'b1;
        end while (!(rsp.bvalid && req.bready) && n < 50);
        req.bready <= 1'b0;
        if (n >= 50) expire();
        cmp(32'(rsp.bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        req.araddr <= a;
        req.arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) req.rready <= 1'b1;
        end while (!(rsp.rvalid && req.rready) && n < 50);
        req.rready <= 1'b0;
        if (n >= 50) expire();
        cmp(rsp.rdata, d);
        cmp(32'(rsp.rresp), 32'(er));
    endtask
    task automatic flip(output int n);
        logic v;
        v = lvl_a;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (lvl_a === v && n < 600);
        if (n >= 600) expire();
    endtask
    initial begin
        void'($urandom(32'h9E22));
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cmp(32'(lvl_a), 32'h1);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_PRESC, 32'h0, RESP_OKAY);
        wr(OFS_PORT, 32'hC, RESP_OKAY);
        cmp(32'(lvl_a), 32'h0);
        cmp(32'(lvl_b), 32'h0);
        wr(OFS_CTRL, 32'hC0, RESP_OKAY);
        wr(OFS_FORCE, 32'h1, RESP_OKAY);
        cmp(32'(lvl_a), 32'h1);
        wr(OFS_CTRL, 32'h100, RESP_OKAY);
        wr(OFS_COUNT, 32'hF0, RESP_OKAY);
        hi = 0;
        while (flags.overflow_flag !== 1'b1 && hi < 40) begin
            @(posedge aclk);
            hi++;
        end
        if (hi >= 40) expire();
        wr(OFS_CTRL, 32'h0, RESP_OKAY);
        wr(OFS_FLAGS, 32'h7, RESP_OKAY);
        rd(OFS_FLAGS, 32'h0, RESP_OKAY);
        rd(OFS_STATUS, 32'h1, RESP_OKAY);
        wr(OFS_COUNT, 32'h0, RESP_OKAY);
        wr(OFS_CTRL, 32'h142, RESP_OKAY);
        rd(OFS_FLAGS, 32'h0, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 8'h00 : 8'($urandom_range(1, 40));
            wr(OFS_CMPA, 32'(c), RESP_OKAY);
            flip(hi);
            flip(hi);
            cmp(hi, 32'(c) + 1);
        end
        cmp(32'(flags.compare_a_flag), 32'h1);
        cmp(32'(flags.compare_b_flag), 32'h1);
        for (int j = 0; j < 6; j++) begin
            c = (j < 2) ? 8'h00 : (j < 4) ? 8'hFF : 8'($urandom_range(1, 254));
            wr(OFS_CMPA, 32'(c), RESP_OKAY);
            wr(OFS_CTRL, j[0] ? 32'h1C3 : 32'h183, RESP_OKAY);
            repeat (300) @(posedge aclk);
            hi = 0;
            repeat (256) begin
                @(posedge aclk);
                hi += int'(lvl_a);
            end
            cmp(hi, exp_hi(c, j[0]));
        end
        wr(OFS_CTRL, 32'h147, RESP_OKAY);
        flip(hi);
        flip(hi);
        cmp(hi, 32'(c) + 1);
        tally_and_finish();
    end
endmodule
bind tw8_waveform_gen tw8_chk chk (.aclk(aclk), .aresetn(aresetn),
    .s_axil_req(s_axil_req), .s_axil_rsp(s_axil_rsp), .pin(pin),
    .flags(flags));
